// file: hw/srs_pkg.sv
package srs_pkg;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_INSTR    = 8'h00;
   localparam logic [7:0] ADDR_SRC      = 8'h04;
   localparam logic [7:0] ADDR_BASE     = 8'h08;
   localparam logic [7:0] ADDR_IDX      = 8'h0c;
   localparam logic [7:0] ADDR_FPR_HI   = 8'h10;
   localparam logic [7:0] ADDR_FPR_LO   = 8'h14;
   localparam logic [7:0] ADDR_CTRL     = 8'h18;
   localparam logic [7:0] ADDR_RESULT   = 8'h1c;
   localparam logic [7:0] ADDR_EADDR    = 8'h20;
   localparam logic [7:0] ADDR_STATUS   = 8'h24;
   localparam logic [7:0] ADDR_SDATA_HI = 8'h28;
   localparam logic [7:0] ADDR_SDATA_LO = 8'h2c;

   // ==========================================================
   // field positions and reset values
   localparam int CTRL_GO    = 0;
   localparam int CTRL_SO    = 1;
   localparam int STAT_CARRY = 0;
   localparam int STAT_COND  = 1;
   localparam int STAT_ILL   = 5;
   localparam int STAT_CNT   = 8;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ==========================================================
   // primary and extended opcodes
   localparam logic [5:0] OP_XFORM   = 6'h1f;
   localparam logic [5:0] OP_ST_W    = 6'h24;
   localparam logic [5:0] OP_ST_WU   = 6'h25;
   localparam logic [5:0] OP_ST_B    = 6'h26;
   localparam logic [5:0] OP_ST_BU   = 6'h27;
   localparam logic [5:0] OP_ST_H    = 6'h2c;
   localparam logic [5:0] OP_ST_HU   = 6'h2d;
   localparam logic [5:0] OP_ST_FS   = 6'h34;
   localparam logic [5:0] OP_ST_FSU  = 6'h35;
   localparam logic [5:0] OP_ST_FD   = 6'h36;
   localparam logic [5:0] OP_ST_FDU  = 6'h37;
   localparam logic [9:0] XO_SRA_IMM = 10'h338;
   localparam logic [9:0] XO_SRL     = 10'h218;
   localparam logic [9:0] XO_ST_B    = 10'h0d7;
   localparam logic [9:0] XO_ST_BU   = 10'h0f7;
   localparam logic [9:0] XO_ST_H    = 10'h197;
   localparam logic [9:0] XO_ST_HU   = 10'h1b7;
   localparam logic [9:0] XO_ST_W    = 10'h097;
   localparam logic [9:0] XO_ST_WU   = 10'h0b7;
   localparam logic [9:0] XO_ST_FD   = 10'h2d7;
   localparam logic [9:0] XO_ST_FDU  = 10'h2f7;
   localparam logic [9:0] XO_ST_FS   = 10'h297;
   localparam logic [9:0] XO_ST_FSU  = 10'h2b7;
   localparam logic [9:0] XO_ST_FIW  = 10'h3d7;

   // ==========================================================
   // store sizes in bytes, single conversion threshold
   localparam logic [3:0]  SIZE_BYTE   = 4'h1;
   localparam logic [3:0]  SIZE_HALF   = 4'h2;
   localparam logic [3:0]  SIZE_WORD   = 4'h4;
   localparam logic [3:0]  SIZE_DBL    = 4'h8;
   localparam logic [10:0] SGL_EXP_MIN = 11'h380;

   typedef enum logic [2:0] {
      SRS_ST_NONE, SRS_ST_BYTE, SRS_ST_HALF, SRS_ST_WORD, SRS_ST_DBL, SRS_ST_SGL, SRS_ST_FIW
   } srs_st_t;

   typedef enum logic [1:0] {SRS_SR_NONE, SRS_SR_ARITH, SRS_SR_LOGIC} srs_sr_t;

endpackage : srs_pkg

// file: hw/srs_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module srs_shifter #(
   parameter int WIDTH = 32,
   parameter int AMT_W = 5
) (
   // operands
   input  wire logic [WIDTH-1:0] src_i,
   input  wire logic [AMT_W-1:0] amt_i,
   input  wire logic             arith_i,
   input  wire logic             clear_i,
   // result
   output logic      [WIDTH-1:0] res_o,
   output logic                  carry_o
);

   logic [WIDTH-1:0] lost_mask;
   logic [WIDTH-1:0] fill;
   logic             sign;

   // ==========================================================
   // right shift with sign or zero fill
   assign sign      = arith_i & src_i[WIDTH-1];
   assign lost_mask = ~({WIDTH{1'b1}} << amt_i);
   assign fill      = sign ? ~({WIDTH{1'b1}} >> amt_i) : '0;   // [RL1]
   assign res_o     = clear_i ? '0 : ((src_i >> amt_i) | fill); // [RL4] [RL5]
   // zero amount gives an empty mask, so carry is clear
   assign carry_o   = sign & (|(src_i & lost_mask));           // [RL2] [RL3]

endmodule : srs_shifter
`default_nettype wire

// file: hw/srs_store_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module srs_store_fmt (
   // operands
   input  wire srs_pkg::srs_st_t kind_i,
   input  wire logic [31:0]      gpr_i,
   input  wire logic [63:0]      fpr_i,
   // memory data
   output logic      [63:0]      data_o,
   output logic      [3:0]       size_o
);

   // ==========================================================
   // double to single format
   function automatic logic [31:0] to_single(input logic [63:0] d);
      logic [10:0] ex;
      logic [10:0] amt;
      logic [23:0] mant;
      ex   = d[62:52];
      amt  = 11'(11'h381 - ex);
      mant = {1'b1, d[51:29]} >> amt;
      if (ex > srs_pkg::SGL_EXP_MIN || d[62:0] == 63'h0) begin
         return {d[63:62], d[58:29]};
      end
      return {d[63], 8'h00, mant[22:0]};
   endfunction : to_single

   always_comb begin
      data_o = 64'h0;
      size_o = 4'h0;
      case (kind_i)
         srs_pkg::SRS_ST_BYTE: begin
            data_o = {56'h0, gpr_i[7:0]};                 // [RL9]
            size_o = srs_pkg::SIZE_BYTE;
         end
         srs_pkg::SRS_ST_HALF: begin
            data_o = {48'h0, gpr_i[15:0]};                // [RL11]
            size_o = srs_pkg::SIZE_HALF;
         end
         srs_pkg::SRS_ST_WORD: begin
            data_o = {32'h0, gpr_i};
            size_o = srs_pkg::SIZE_WORD;
         end
         srs_pkg::SRS_ST_DBL: begin
            data_o = fpr_i;                               // [RL14]
            size_o = srs_pkg::SIZE_DBL;
         end
         srs_pkg::SRS_ST_SGL: begin
            data_o = {32'h0, to_single(fpr_i)};           // [RL15]
            size_o = srs_pkg::SIZE_WORD;
         end
         srs_pkg::SRS_ST_FIW: begin
            // raw low word; value origin is not tracked
            data_o = {32'h0, fpr_i[31:0]};                // [RL16] [RL17]
            size_o = srs_pkg::SIZE_WORD;
         end
         default: begin
            data_o = 64'h0;
            size_o = 4'h0;
         end
      endcase
   end

endmodule : srs_store_fmt
`default_nettype wire

// file: hw/srs_exec_top.sv
// What this block does
// RL1 - immediate arithmetic right shift fills vacated high bits with the sign bit
// RL2 - arithmetic shift sets carry when negative source loses any one bit
// RL3 - arithmetic shift by zero leaves the carry flag cleared
// RL4 - logical shift by amount register low five bits, zero fill, bit five clear
// RL5 - logical shift gives zero when amount register bit five is set
// RL6 - record bit set updates less, greater, equal and overflow copy of field zero
// RL7 - displacement address is sign-extended offset plus base, or zero base
// RL8 - indexed address is index plus base, or zero base
// RL9 - byte store writes source low byte
// RL10 - stores never modify the source; plain stores write no register
// RL11 - half-word store writes source low sixteen bits
// RL12 - update stores write effective address back to the base register
// RL13 - software must not use update form with base field zero
// RL14 - double floating store writes full 64-bit register unchanged
// RL15 - single floating store converts to single format, writes a word
// RL16 - raw floating word store writes low 32 bits without conversion
// RL17 - raw word store data may be undefined after single-precision producers
// RL18 - primary and extended opcodes select shift, store width, form, update
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module srs_exec_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // apb slave
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // memory side
   output logic             mem_wr_o,
   output logic      [31:0] mem_addr_o,
   output logic      [63:0] mem_wdata_o,
   output logic      [3:0]  mem_size_o,
   // register write-back
   output logic             gpr_we_o,
   output logic      [4:0]  gpr_waddr_o,
   output logic      [31:0] gpr_wdata_o,
   // flags
   output logic             carry_flag_o,
   output logic      [3:0]  condition_field_zero_o,
   output logic             illegal_o
);

   logic              rst_meta_ff;
   logic              rst_n;
   logic [31:0]       instr_ff;
   logic [31:0]       src_ff;
   logic [31:0]       base_ff;
   logic [31:0]       idx_ff;
   logic [63:0]       fpr_ff;
   logic              so_ff;
   logic              go_ff;
   logic [7:0]        cnt_ff;
   logic              pready_ff;
   logic [31:0]       prdata_ff;
   logic              pslverr_ff;
   logic [31:0]       nxt_prdata;
   logic              nxt_pslverr;
   logic              wr_take;
   srs_pkg::srs_st_t  st_kind;
   srs_pkg::srs_sr_t  sr_kind;
   logic              use_idx;
   logic              upd;
   logic              record_bit;
   logic [4:0]        base_fld;
   logic [31:0]       base_val;
   logic [31:0]       effective_address;
   logic [31:0]       sr_res;
   logic              sr_carry;
   logic [63:0]       st_data;
   logic [3:0]        st_size;
   logic [3:0]        cond;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // reset release
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // ==========================================================
   // apb slave, one wait state
   assign wr_take = psel_i & penable_i & pready_ff & pwrite_i;

   always_comb begin
      nxt_prdata  = 32'h0;
      nxt_pslverr = 1'b0;
      case (paddr_i)
         srs_pkg::ADDR_INSTR:    nxt_prdata = instr_ff;
         srs_pkg::ADDR_SRC:      nxt_prdata = src_ff;
         srs_pkg::ADDR_BASE:     nxt_prdata = base_ff;
         srs_pkg::ADDR_IDX:      nxt_prdata = idx_ff;
         srs_pkg::ADDR_FPR_HI:   nxt_prdata = fpr_ff[63:32];
         srs_pkg::ADDR_FPR_LO:   nxt_prdata = fpr_ff[31:0];
         srs_pkg::ADDR_CTRL:     nxt_prdata = {30'h0, so_ff, 1'b0};
         srs_pkg::ADDR_RESULT:   nxt_prdata = gpr_wdata_o;
         srs_pkg::ADDR_EADDR:    nxt_prdata = mem_addr_o;
         srs_pkg::ADDR_STATUS: begin
            nxt_prdata[srs_pkg::STAT_CARRY]                  = carry_flag_o;
            nxt_prdata[srs_pkg::STAT_COND +: 4]              = condition_field_zero_o;
            nxt_prdata[srs_pkg::STAT_ILL]                    = illegal_o;
            nxt_prdata[srs_pkg::STAT_CNT +: 8]               = cnt_ff;
         end
         srs_pkg::ADDR_SDATA_HI: nxt_prdata = mem_wdata_o[63:32];
         srs_pkg::ADDR_SDATA_LO: nxt_prdata = mem_wdata_o[31:0];
         default:                nxt_pslverr = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= srs_pkg::RST_WORD;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel_i & penable_i & ~pready_ff;
         prdata_ff  <= (psel_i & penable_i & ~pready_ff & ~pwrite_i) ? nxt_prdata : srs_pkg::RST_WORD;
         pslverr_ff <= psel_i & penable_i & ~pready_ff & nxt_pslverr;
      end
   end

   // ==========================================================
   // operand and control registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         instr_ff <= srs_pkg::RST_WORD;
         src_ff   <= srs_pkg::RST_WORD;
         base_ff  <= srs_pkg::RST_WORD;
         idx_ff   <= srs_pkg::RST_WORD;
         fpr_ff   <= 64'h0;
         so_ff    <= 1'b0;
         go_ff    <= 1'b0;
      end else begin
         go_ff <= wr_take && paddr_i == srs_pkg::ADDR_CTRL && pwdata_i[srs_pkg::CTRL_GO];
         if (wr_take) begin
            case (paddr_i)
               srs_pkg::ADDR_INSTR:  instr_ff      <= pwdata_i;
               srs_pkg::ADDR_SRC:    src_ff        <= pwdata_i;
               srs_pkg::ADDR_BASE:   base_ff       <= pwdata_i;
               srs_pkg::ADDR_IDX:    idx_ff        <= pwdata_i;
               srs_pkg::ADDR_FPR_HI: fpr_ff[63:32] <= pwdata_i;
               srs_pkg::ADDR_FPR_LO: fpr_ff[31:0]  <= pwdata_i;
               srs_pkg::ADDR_CTRL:   so_ff         <= pwdata_i[srs_pkg::CTRL_SO];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // instruction decode
   assign base_fld   = instr_ff[20:16];
   assign record_bit = instr_ff[0];

   always_comb begin
      st_kind = srs_pkg::SRS_ST_NONE;
      sr_kind = srs_pkg::SRS_SR_NONE;
      use_idx = 1'b0;
      upd     = 1'b0;
      case (instr_ff[31:26]) // [RL18]
         srs_pkg::OP_ST_B, srs_pkg::OP_ST_BU:   st_kind = srs_pkg::SRS_ST_BYTE;
         srs_pkg::OP_ST_H, srs_pkg::OP_ST_HU:   st_kind = srs_pkg::SRS_ST_HALF;
         srs_pkg::OP_ST_W, srs_pkg::OP_ST_WU:   st_kind = srs_pkg::SRS_ST_WORD;
         srs_pkg::OP_ST_FS, srs_pkg::OP_ST_FSU: st_kind = srs_pkg::SRS_ST_SGL;
         srs_pkg::OP_ST_FD, srs_pkg::OP_ST_FDU: st_kind = srs_pkg::SRS_ST_DBL;
         srs_pkg::OP_XFORM: begin
            use_idx = 1'b1;
            case (instr_ff[10:1])
               srs_pkg::XO_SRA_IMM:                  sr_kind = srs_pkg::SRS_SR_ARITH;
               srs_pkg::XO_SRL:                      sr_kind = srs_pkg::SRS_SR_LOGIC;
               srs_pkg::XO_ST_B, srs_pkg::XO_ST_BU:   st_kind = srs_pkg::SRS_ST_BYTE;
               srs_pkg::XO_ST_H, srs_pkg::XO_ST_HU:   st_kind = srs_pkg::SRS_ST_HALF;
               srs_pkg::XO_ST_W, srs_pkg::XO_ST_WU:   st_kind = srs_pkg::SRS_ST_WORD;
               srs_pkg::XO_ST_FS, srs_pkg::XO_ST_FSU: st_kind = srs_pkg::SRS_ST_SGL;
               srs_pkg::XO_ST_FD, srs_pkg::XO_ST_FDU: st_kind = srs_pkg::SRS_ST_DBL;
               srs_pkg::XO_ST_FIW:                   st_kind = srs_pkg::SRS_ST_FIW;
               default: ;
            endcase
            upd = instr_ff[6];
         end
         default: ;
      endcase
      if (instr_ff[31:26] != srs_pkg::OP_XFORM) begin
         upd = instr_ff[26];
      end
      if (st_kind == srs_pkg::SRS_ST_NONE || st_kind == srs_pkg::SRS_ST_FIW) begin
         upd = 1'b0;
      end
   end

   // ==========================================================
   // effective address
   // base field zero with update is left to software
   assign base_val          = (base_fld == 5'h0) ? 32'h0 : base_ff;   // [RL13]
   assign effective_address = base_val + (use_idx ? idx_ff : {{16{instr_ff[15]}}, instr_ff[15:0]}); // [RL7] [RL8]

   // ==========================================================
   // datapath units
   srs_shifter #(.WIDTH (32), .AMT_W (5)) u_shifter (
      .src_i   (src_ff),
      .amt_i   ((sr_kind == srs_pkg::SRS_SR_ARITH) ? instr_ff[15:11] : idx_ff[4:0]),
      .arith_i (sr_kind == srs_pkg::SRS_SR_ARITH),
      .clear_i ((sr_kind == srs_pkg::SRS_SR_LOGIC) & idx_ff[5]),
      .res_o   (sr_res),
      .carry_o (sr_carry)
   );

   srs_store_fmt u_store_fmt (
      .kind_i (st_kind),
      .gpr_i  (src_ff),
      .fpr_i  (fpr_ff),
      .data_o (st_data),
      .size_o (st_size)
   );

   assign cond = {sr_res[31], ~sr_res[31] & (|sr_res), ~(|sr_res), so_ff};

   // ==========================================================
   // execute and retire
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_wr_o               <= 1'b0;
         mem_addr_o             <= srs_pkg::RST_WORD;
         mem_wdata_o            <= 64'h0;
         mem_size_o             <= 4'h0;
         gpr_we_o               <= 1'b0;
         gpr_waddr_o            <= 5'h0;
         gpr_wdata_o            <= srs_pkg::RST_WORD;
         carry_flag_o           <= 1'b0;
         condition_field_zero_o <= 4'h0;
         illegal_o              <= 1'b0;
         cnt_ff                 <= 8'h0;
      end else begin
         mem_wr_o <= 1'b0;
         gpr_we_o <= 1'b0;
         if (go_ff) begin
            cnt_ff    <= 8'(cnt_ff + 8'h1);
            illegal_o <= (st_kind == srs_pkg::SRS_ST_NONE) && (sr_kind == srs_pkg::SRS_SR_NONE);
            if (sr_kind != srs_pkg::SRS_SR_NONE) begin
               gpr_we_o    <= 1'b1;
               gpr_waddr_o <= base_fld;
               gpr_wdata_o <= sr_res;                             // [RL1] [RL4] [RL5]
               if (sr_kind == srs_pkg::SRS_SR_ARITH) begin
                  carry_flag_o <= sr_carry;                       // [RL2] [RL3]
               end
               if (record_bit) begin
                  condition_field_zero_o <= cond;                 // [RL6]
               end
            end
            if (st_kind != srs_pkg::SRS_ST_NONE) begin
               mem_wr_o    <= 1'b1;
               mem_addr_o  <= effective_address;
               mem_wdata_o <= st_data;
               mem_size_o  <= st_size;
               // source is only read; plain stores retire no register
               gpr_we_o    <= upd;                                // [RL10] [RL12]
               gpr_waddr_o <= base_fld;
               gpr_wdata_o <= effective_address;
            end
         end
      end
   end

   assign prdata_o  = prdata_ff;
   assign pready_o  = pready_ff;
   assign pslverr_o = pslverr_ff;

   // ==========================================================
   // checks
   sequence s_go_sra;
      go_ff && sr_kind == srs_pkg::SRS_SR_ARITH;
   endsequence
   sequence s_go_srl;
      go_ff && sr_kind == srs_pkg::SRS_SR_LOGIC;
   endsequence
   sequence s_go_st;
      go_ff && st_kind != srs_pkg::SRS_ST_NONE;
   endsequence
   property p_sra_value;
      s_go_sra |=> gpr_wdata_o == 32'($signed($past(src_ff)) >>> $past(instr_ff[15:11]));
   endproperty
   a_sra_value: assert property (p_sra_value) else $error("arith shift result wrong"); // [RL1]
   property p_sra_carry;
      s_go_sra |=> carry_flag_o == ($past(src_ff[31]) && ($past(src_ff) << (6'd32 - $past(instr_ff[15:11]))) != 0);
   endproperty
   a_sra_carry: assert property (p_sra_carry) else $error("carry flag wrong"); // [RL2]
   property p_sra_zero;
      s_go_sra ##0 instr_ff[15:11] == 5'h0 |=> !carry_flag_o ##1 $stable(carry_flag_o);
   endproperty
   a_sra_zero: assert property (p_sra_zero) else $error("zero shift set carry"); // [RL3]
   property p_srl_value;
      s_go_srl ##0 !idx_ff[5] |=> gpr_we_o && gpr_wdata_o == ($past(src_ff) >> $past(idx_ff[4:0]));
   endproperty
   a_srl_value: assert property (p_srl_value) else $error("logical shift result wrong"); // [RL4]
   property p_srl_clear;
      s_go_srl ##0 idx_ff[5] |=> gpr_we_o && gpr_wdata_o == 32'h0;
   endproperty
   a_srl_clear: assert property (p_srl_clear) else $error("logical shift not cleared"); // [RL5]
   property p_record;
      (s_go_sra or s_go_srl) ##0 record_bit |=>
         condition_field_zero_o[1] == (gpr_wdata_o == 32'h0) &&
         condition_field_zero_o[3] == gpr_wdata_o[31] && condition_field_zero_o[0] == so_ff;
   endproperty
   a_record: assert property (p_record) else $error("condition field wrong"); // [RL6]
   property p_disp_addr;
      s_go_st ##0 !use_idx |=> mem_wr_o &&
         mem_addr_o == ($past(base_fld) == 5'h0 ? 32'h0 : $past(base_ff)) + 32'($signed($past(instr_ff[15:0])));
   endproperty
   a_disp_addr: assert property (p_disp_addr) else $error("displacement address wrong"); // [RL7]
   property p_idx_addr;
      s_go_st ##0 use_idx |=> mem_wr_o &&
         mem_addr_o == ($past(base_fld) == 5'h0 ? 32'h0 : $past(base_ff)) + $past(idx_ff);
   endproperty
   a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong"); // [RL8]
   property p_byte_data;
      s_go_st ##0 st_kind == srs_pkg::SRS_ST_BYTE |=> mem_size_o == 4'h1 && mem_wdata_o == {56'h0, $past(src_ff[7:0])};
   endproperty
   a_byte_data: assert property (p_byte_data) else $error("byte store data wrong"); // [RL9]
   property p_plain_store;
      s_go_st ##0 !upd |=> !gpr_we_o ##1 !gpr_we_o;
   endproperty
   a_plain_store: assert property (p_plain_store) else $error("plain store wrote a register"); // [RL10]
   property p_update;
      s_go_st ##0 upd |=> gpr_we_o && gpr_waddr_o == $past(base_fld) && gpr_wdata_o == mem_addr_o ##1 !gpr_we_o;
   endproperty
   a_update: assert property (p_update) else $error("update write-back wrong"); // [RL12]
endmodule : srs_exec_top
`default_nettype wire

// file: tb/srs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module srs_mem_model (
   // store request
   input  wire logic        clk_i,
   input  wire logic        mem_wr_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [63:0] wdata_i,
   input  wire logic [3:0]  size_i,
   // last store seen
   output logic      [7:0]  n_st_o,
   output logic      [31:0] addr_o,
   output logic      [63:0] data_o,
   output logic      [3:0]  size_o
);
   // ==========================================================
   // memory side: takes each store whole in its pulse cycle
   initial n_st_o = 8'h00;
   always @(posedge clk_i) begin
      if (mem_wr_i === 1'b1) begin
         n_st_o <= n_st_o + 8'h01;
         addr_o <= addr_i;
         data_o <= wdata_i;
         size_o <= size_i;
      end
   end
endmodule : srs_mem_model
`default_nettype wire

// file: tb/srs_exec_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module srs_exec_top_test;
   // ==========================================================
   // signals
   logic        clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, mem_wr_o, gpr_we_o, err;
   logic        carry_flag_o, illegal_o, so = 1'b0;
   logic [7:0]  paddr_i, n_st;
   logic [31:0] pwdata_i, prdata_o, mem_addr_o, gpr_wdata_o, st_addr, rd, we_data;
   logic [63:0] mem_wdata_o, st_data;
   logic [3:0]  mem_size_o, condition_field_zero_o, st_size;
   logic [4:0]  gpr_waddr_o, we_addr;
   int          n_fail = 0, total_checks = 0, n_we = 0;
   srs_exec_top srs_exec_top_inst (.clk_i, .arst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .mem_size_o, .gpr_we_o,
      .gpr_waddr_o, .gpr_wdata_o, .carry_flag_o, .condition_field_zero_o, .illegal_o);
   srs_mem_model srs_mem_model_inst (.clk_i, .mem_wr_i(mem_wr_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .size_i(mem_size_o), .n_st_o(n_st), .addr_o(st_addr), .data_o(st_data), .size_o(st_size));
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (gpr_we_o === 1'b1) begin
         n_we <= n_we + 1;
         we_addr <= gpr_waddr_o;
         we_data <= gpr_wdata_o;
      end
   end
   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] a, input logic [4:0] b,
                                      input logic rec);
      return {srs_pkg::OP_XFORM, 5'h01, a, b, xo, rec};
   endfunction : xf
   task automatic exec(input logic [31:0] ins);
      apb(1'b1, srs_pkg::ADDR_INSTR, ins);
      apb(1'b1, srs_pkg::ADDR_CTRL, {30'h0, so, 1'b1});
      repeat (3) @(posedge clk_i);
   endtask : exec
   task automatic shf(input logic [31:0] ins, input logic [31:0] res, input logic [5:0] st);
      int we0;
      we0 = n_we;
      exec(ins);
      apb(1'b0, srs_pkg::ADDR_RESULT, 32'h0);
      chk("result", res, rd);
      chk("gpr writes", we0 + 1, n_we);
      chk("dest field", ins[20:16], we_addr);
      apb(1'b0, srs_pkg::ADDR_STATUS, 32'h0);
      chk("status", st, rd[5:0]);
   endtask : shf
   task automatic sto(input logic [31:0] ins, input logic [31:0] adr, input logic [63:0] d, input logic [3:0] sz,
                      input logic upd);
      int we0, ns0;
      we0 = n_we;
      ns0 = n_st;
      exec(ins);
      chk("stores", ns0 + 1, n_st);
      chk("address", adr, st_addr);
      chk("data", d, st_data);
      chk("size", sz, st_size);
      chk("gpr writes", we0 + upd, n_we);
      if (upd) chk("writeback", {ins[20:16], adr}, {we_addr, we_data});
      apb(1'b1, srs_pkg::ADDR_BASE, 32'h1000);
   endtask : sto
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   // ==========================================================
   // scenarios
   task automatic t_shift();
      apb(1'b1, srs_pkg::ADDR_SRC, 32'h8000_0013);
      shf(xf(srs_pkg::XO_SRA_IMM, 5'h03, 5'h04, 1'b1), 32'hf800_0001, 6'b010001);
      shf(xf(srs_pkg::XO_SRA_IMM, 5'h03, 5'h00, 1'b0), 32'h8000_0013, 6'b010000);
      apb(1'b1, srs_pkg::ADDR_IDX, 32'h0000_0005);
      shf(xf(srs_pkg::XO_SRL, 5'h07, 5'h02, 1'b1), 32'h0400_0000, 6'b001000);
      apb(1'b1, srs_pkg::ADDR_IDX, 32'h0000_0025);
      shf(xf(srs_pkg::XO_SRL, 5'h07, 5'h02, 1'b1), 32'h0, 6'b000100);
      apb(1'b1, srs_pkg::ADDR_SRC, 32'h0000_000f);
      so = 1'b1;
      shf(xf(srs_pkg::XO_SRA_IMM, 5'h03, 5'h02, 1'b1), 32'h3, 6'b001010);
   endtask : t_shift
   task automatic t_store();
      apb(1'b1, srs_pkg::ADDR_SRC, 32'h1234_abcd);
      apb(1'b1, srs_pkg::ADDR_BASE, 32'h1000);
      apb(1'b1, srs_pkg::ADDR_IDX, 32'h10);
      apb(1'b1, srs_pkg::ADDR_FPR_HI, 32'h4000_0001);
      apb(1'b1, srs_pkg::ADDR_FPR_LO, 32'h89ab_cdef);
      sto({srs_pkg::OP_ST_B, 5'h01, 5'h03, 16'hfffc}, 32'h0ffc, 64'hcd, 4'h1, 1'b0);
      sto({srs_pkg::OP_ST_B, 5'h01, 5'h00, 16'h0008}, 32'h8, 64'hcd, 4'h1, 1'b0);
      sto(xf(srs_pkg::XO_ST_W, 5'h00, 5'h02, 1'b0), 32'h10, 64'h1234_abcd, 4'h4, 1'b0);
      sto(xf(srs_pkg::XO_ST_HU, 5'h05, 5'h02, 1'b0), 32'h1010, 64'habcd, 4'h2, 1'b1);
      sto({srs_pkg::OP_ST_WU, 5'h01, 5'h04, 16'h0020}, 32'h1020, 64'h1234_abcd, 4'h4, 1'b1);
      sto(xf(srs_pkg::XO_ST_FDU, 5'h06, 5'h02, 1'b0), 32'h1010, 64'h4000_0001_89ab_cdef, 4'h8, 1'b1);
      sto(xf(srs_pkg::XO_ST_FIW, 5'h03, 5'h02, 1'b0), 32'h1010, 64'h89ab_cdef, 4'h4, 1'b0);
      apb(1'b1, srs_pkg::ADDR_FPR_HI, 32'h3ff0_0000);
      apb(1'b1, srs_pkg::ADDR_FPR_LO, 32'h0);
      sto({srs_pkg::OP_ST_FS, 5'h01, 5'h03, 16'h0004}, 32'h1004, 64'h3f80_0000, 4'h4, 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {1'b1, 32'h0}, {err, rd});
      exec(32'h0);
      apb(1'b0, srs_pkg::ADDR_STATUS, 32'h0);
      chk("status", 16'h0e2a, rd[15:0]);
   endtask : t_store
   // ==========================================================
   // main sequence and watchdog
   initial begin
      clk_i = 1'b0;
      arst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_shift();
      t_store();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      results();
   end
endmodule : srs_exec_top_test
`default_nettype wire
